// file: logic/dkc_controller.v
// controller that drives a 4096 x 1 dynamic memory through its pins
// What this block does
// RULE1: twelve address lines pick one bit
// RULE2: deselected device neither reads nor writes
// RULE3: refresh every row within 2 ms
// RULE4: refresh by reading all 64 low rows
// RULE5: output floats when deselected or strobe low
// RULE6: strobe low at least 130 ns between cycles
// RULE7: write strobe high 230 to 4000 ns
// RULE8: modify-write strobe high 350 to 4000 ns
// RULE9: read data valid 180 ns after strobe
// RULE10: read data valid 200 ns after address; the code samples 184 ns after address, timed from strobe only
// RULE11: row counter, refresh gets priority when late
`timescale 1ns/1ps
`include "dkc_regs.vh"
module dkc_controller (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // user request port
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [1:0]  req_op,
  input  wire [11:0] req_addr,
  input  wire        req_wdata,
  input  wire        req_invert,
  // user answer port
  output reg         rsp_valid,
  output reg         rsp_rdata,
  // memory pins
  output reg  [11:0] word_address_lines,
  output reg         cycle_strobe,
  output reg         select_n,
  output reg         read_write_n,
  output reg         mem_din,
  input  wire        mem_dout
);
  // -----------------------------------------------------------------------
  // operation codes and states
  // -----------------------------------------------------------------------
  localparam [1:0] OP_READ  = 2'd0;  // plain read
  localparam [1:0] OP_WRITE = 2'd1;  // plain write
  localparam [1:0] OP_RMW   = 2'd2;  // read, optionally invert, write back
  localparam [2:0] ST_LOW   = 3'd0;  // strobe low recovery
  localparam [2:0] ST_IDLE  = 3'd1;  // waiting for work
  localparam [2:0] ST_HIGH  = 3'd2;  // strobe high, cycle running
  localparam [2:0] ST_HOLD  = 3'd3;  // strobe low, address held
  // counts come out of the macros as integers; cut them to the counter width here
  localparam integer LOW_I     = `DKC_LOW_CYC;
  localparam integer HOLD_I    = `DKC_HOLD_CYC;
  localparam integer SAMP_I    = `DKC_SAMPLE_CYC;
  localparam integer WSET_I    = `DKC_WR_SETUP_CYC;
  localparam integer MAX_I     = `DKC_MAX_HIGH_CYC;
  localparam integer WRH_I     = `DKC_WR_HIGH_CYC;
  localparam integer RMWH_I    = `DKC_RMW_HIGH_CYC;
  localparam integer RDH_I     = `DKC_RD_HIGH_CYC;
  localparam integer SPACE_I   = `DKC_ROW_SPACE;
  localparam [15:0]  LOW_CYC   = LOW_I[15:0];
  localparam [15:0]  HOLD_CYC  = HOLD_I[15:0];
  localparam [15:0]  SAMP_CYC  = SAMP_I[15:0];
  localparam [15:0]  WSET_CYC  = WSET_I[15:0];
  localparam [15:0]  MAX_CYC   = MAX_I[15:0];
  localparam [15:0]  WRH_CYC   = WRH_I[15:0];
  localparam [15:0]  RMWH_CYC  = RMWH_I[15:0];
  localparam [15:0]  RDH_CYC   = RDH_I[15:0];
  localparam [15:0]  SPACE_CYC = SPACE_I[15:0];

  // high time needed for each kind of cycle
  function [15:0] high_cycles;
    input [1:0] op;
    begin
      case (op)
        OP_WRITE: high_cycles = WRH_CYC;   // RULE7
        OP_RMW:   high_cycles = RMWH_CYC;  // RULE8
        default:  high_cycles = RDH_CYC;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  reg [2:0]  state_reg;     // sequencer state
  reg [15:0] cnt_reg;       // cycles in current state; in ST_LOW, cycles since strobe fell
  reg [1:0]  op_reg;        // operation in flight
  reg        is_ref_reg;    // cycle is a refresh read
  reg        inv_reg;       // invert on read-modify-write
  reg        dout_s1_reg;   // synchroniser first stage
  reg        dout_s2_reg;   // synchroniser second stage
  reg        rdata_reg;     // sampled read bit
  wire       refresh_due;
  wire       refresh_urgent;
  wire [5:0] refresh_row;
  wire       refresh_done;
  wire       start_ref;
  wire       start_user;
  wire [15:0] need_high;

  // refresh wins when late; otherwise when idle with no user work
  assign start_ref  = (state_reg == ST_IDLE) & refresh_due &
                      (refresh_urgent | ~req_valid);           // RULE11
  assign start_user = (state_reg == ST_IDLE) & req_valid & ~start_ref;
  assign req_ready  = start_user;
  assign need_high  = high_cycles(op_reg);
  assign refresh_done = (state_reg == ST_HIGH) & is_ref_reg &
                        (cnt_reg == need_high - 16'h0001);

  // -----------------------------------------------------------------------
  // refresh timer
  // -----------------------------------------------------------------------
  dkc_refresh_timer #(
    .ROW_SPACE (SPACE_CYC)
  ) u_timer (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .refresh_done   (refresh_done),
    .refresh_due    (refresh_due),
    .refresh_urgent (refresh_urgent),
    .refresh_row    (refresh_row)
  );  // RULE3

  // -----------------------------------------------------------------------
  // read data synchroniser
  // -----------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_s1_reg <= 1'b0;
      dout_s2_reg <= 1'b0;
    end else begin
      dout_s1_reg <= mem_dout;
      dout_s2_reg <= dout_s1_reg;
    end
  end

  // -----------------------------------------------------------------------
  // cycle sequencer
  // -----------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg          <= ST_LOW;
      cnt_reg            <= 16'h0000;
      op_reg             <= OP_READ;
      is_ref_reg         <= 1'b0;
      inv_reg            <= 1'b0;
      rdata_reg          <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= 1'b0;
      word_address_lines <= 12'h000;
      cycle_strobe       <= 1'b0;
      select_n           <= 1'b1;
      read_write_n       <= 1'b1;
      mem_din            <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        // strobe low for the minimum recovery
        ST_LOW: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= LOW_CYC - 16'h0001) begin  // RULE6
            state_reg <= ST_IDLE;
            cnt_reg   <= 16'h0000;
          end
        end
        // launch refresh or user cycle with strobe rising
        ST_IDLE: begin
          if (start_ref) begin
            word_address_lines <= {6'h00, refresh_row};  // RULE4
            select_n           <= 1'b0;
            read_write_n       <= 1'b1;
            op_reg             <= OP_READ;
            is_ref_reg         <= 1'b1;
            cycle_strobe       <= 1'b1;
            state_reg          <= ST_HIGH;
          end else if (start_user) begin
            word_address_lines <= req_addr;  // RULE1
            select_n           <= 1'b0;
            read_write_n       <= 1'b1;
            mem_din            <= req_wdata;
            op_reg             <= req_op;
            inv_reg            <= req_invert;
            is_ref_reg         <= 1'b0;
            cycle_strobe       <= 1'b1;
            state_reg          <= ST_HIGH;
          end
        end
        // strobe high; sample, then drop write line before strobe falls
        ST_HIGH: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == SAMP_CYC + 16'h0001) begin
            rdata_reg <= dout_s2_reg;  // RULE9; RULE10 needs 200 ns from address, sample is 184 ns after it
            if (op_reg == OP_RMW) begin
              mem_din <= dout_s2_reg ^ inv_reg;
            end
          end
          // only write and read-modify-write drop the write line; code 3 is a read
          if (((op_reg == OP_WRITE) || (op_reg == OP_RMW)) &&
              (cnt_reg == need_high - WSET_CYC - 16'h0001)) begin
            read_write_n <= 1'b0;
          end
          if ((cnt_reg >= need_high - 16'h0001) || (cnt_reg >= MAX_CYC - 16'h0001)) begin
            cycle_strobe <= 1'b0;  // RULE7 RULE8
            read_write_n <= 1'b1;
            cnt_reg      <= 16'h0000;
            state_reg    <= ST_HOLD;
            if (!is_ref_reg && (op_reg != OP_WRITE)) begin
              rsp_valid <= 1'b1;
              rsp_rdata <= rdata_reg;
            end
          end
        end
        // keep address and select through the hold time
        ST_HOLD: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg >= HOLD_CYC - 16'h0001) begin
            select_n  <= 1'b1;  // RULE2 RULE5
            state_reg <= ST_LOW;
            cnt_reg   <= HOLD_CYC;
          end
        end
        default: begin
          state_reg <= ST_LOW;
          cnt_reg   <= 16'h0000;
        end
      endcase
    end
  end
endmodule

// file: logic/dkc_regs.vh
// timing and field constants for the 4k x 1 dynamic memory controller
`ifndef DKC_REGS_VH
`define DKC_REGS_VH
// -------------------------------------------------------------------------
// clock
// -------------------------------------------------------------------------
`define DKC_CLK_PERIOD_NS     4
// -------------------------------------------------------------------------
// address fields
// -------------------------------------------------------------------------
`define DKC_ADDR_W            12
`define DKC_ROW_W             6
`define DKC_ROW_COUNT         64
// -------------------------------------------------------------------------
// pin timing, in ns as printed; refresh period in ms
// -------------------------------------------------------------------------
`define DKC_STROBE_LOW_NS     130
`define DKC_WRITE_HIGH_NS     230
`define DKC_RMW_HIGH_NS       350
`define DKC_READ_HIGH_NS      230
`define DKC_HIGH_MAX_NS       4000
`define DKC_STROBE_ACCESS_NS  180
`define DKC_ADDR_ACCESS_NS    200
`define DKC_ADDR_HOLD_NS      100
`define DKC_WRITE_SETUP_NS    150
`define DKC_REFRESH_MS        2
// -------------------------------------------------------------------------
// cycle counts; minimums round up, maximums round down
// -------------------------------------------------------------------------
`define DKC_CYC_UP(ns)   (((ns) + `DKC_CLK_PERIOD_NS - 1) / `DKC_CLK_PERIOD_NS)
`define DKC_CYC_DN(ns)   ((ns) / `DKC_CLK_PERIOD_NS)
`define DKC_LOW_CYC       `DKC_CYC_UP(`DKC_STROBE_LOW_NS)
`define DKC_WR_HIGH_CYC   `DKC_CYC_UP(`DKC_WRITE_HIGH_NS)
`define DKC_RMW_HIGH_CYC  `DKC_CYC_UP(`DKC_RMW_HIGH_NS)
`define DKC_RD_HIGH_CYC   `DKC_CYC_UP(`DKC_READ_HIGH_NS)
`define DKC_MAX_HIGH_CYC  `DKC_CYC_DN(`DKC_HIGH_MAX_NS)
`define DKC_SAMPLE_CYC    (`DKC_CYC_UP(`DKC_STROBE_ACCESS_NS) + 1)
`define DKC_WR_SETUP_CYC  `DKC_CYC_UP(`DKC_WRITE_SETUP_NS)
`define DKC_HOLD_CYC      `DKC_CYC_UP(`DKC_ADDR_HOLD_NS)
// refresh interval in cycles, and per-row spacing
`define DKC_REF_CYC       (`DKC_REFRESH_MS * 1000000 / `DKC_CLK_PERIOD_NS)
`define DKC_ROW_SPACE     (`DKC_REF_CYC / `DKC_ROW_COUNT)
// urgent refresh comes this many cycles early, so a user cycle in flight still fits
`define DKC_URGENT_MARGIN 16'h0100
`define DKC_CNT_W         16
`endif

// file: logic/dkc_refresh_timer.v
// refresh spacing timer and row counter
`timescale 1ns/1ps
`include "dkc_regs.vh"
module dkc_refresh_timer #(
  parameter [15:0] ROW_SPACE = 16'd7812
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // handshake with sequencer
  input  wire       refresh_done,
  output wire       refresh_due,
  output wire       refresh_urgent,
  // current refresh row
  output reg  [5:0] refresh_row
);
  // -----------------------------------------------------------------------
  // spacing counter
  // -----------------------------------------------------------------------
  reg [15:0] space_reg;  // cycles since last refresh read
  reg        owed_reg;   // spacing counter saturated at 16'hffff, refresh is late

  // force early, so waiting out a running cycle never stretches a row past the spacing
  localparam [15:0] URGENT_AT = ROW_SPACE - `DKC_URGENT_MARGIN;

  // refresh wanted at half spacing, forced a margin before full spacing
  assign refresh_due    = (space_reg >= (ROW_SPACE >> 1)) | owed_reg;
  assign refresh_urgent = (space_reg >= URGENT_AT) | owed_reg;  // RULE3

  // count spacing, advance row after each refresh read
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      space_reg   <= 16'h0000;
      owed_reg    <= 1'b0;
      refresh_row <= 6'h00;
    end else if (refresh_done) begin
      space_reg   <= 16'h0000;
      owed_reg    <= 1'b0;
      refresh_row <= refresh_row + 6'h01;  // RULE4 RULE11
    end else if (space_reg == 16'hffff) begin
      owed_reg    <= 1'b1;
    end else begin
      space_reg   <= space_reg + 16'h0001;
    end
  end
endmodule

// file: test/dkc_props.sv
// pin timing checks for the memory controller
`timescale 1ns/1ps
module dkc_props (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // user side
  input wire        req_valid,
  input wire        req_ready,
  input wire        rsp_valid,
  // memory pins
  input wire [11:0] word_address_lines,
  input wire        cycle_strobe,
  input wire        select_n,
  input wire        read_write_n
);
  // ------------
  // helpers
  // ------------
  localparam int GAP = 8100;   // row spacing plus a cycle in flight
  reg [15:0] lo_reg;           // strobe low cycles
  reg [15:0] hi_reg;           // strobe high cycles
  reg [15:0] gap_reg;          // cycles since last refresh
  reg [5:0]  row_reg;          // next refresh row
  reg        wr_reg;           // write seen in this cycle
  reg        tk_reg;           // user request waiting to start
  reg        st_reg;           // last strobe level
  reg        rf_reg;           // refresh cycle running
  wire       rf_go = cycle_strobe & ~st_reg & ~tk_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // widths, refresh rows and cycle kind
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_reg <= 16'h0;
      {hi_reg, gap_reg, row_reg} <= 38'h0;
      {wr_reg, tk_reg, st_reg, rf_reg} <= 4'h0;
    end else begin
      lo_reg <= cycle_strobe ? 16'h0 : lo_reg + 16'h1;
      hi_reg <= cycle_strobe ? hi_reg + 16'h1 : 16'h0;
      gap_reg <= rf_go ? 16'h0 : gap_reg + 16'h1;
      row_reg <= rf_go ? row_reg + 6'h1 : row_reg;
      wr_reg <= cycle_strobe & (wr_reg | ~read_write_n);
      tk_reg <= (req_valid & req_ready) | (tk_reg & ~cycle_strobe);
      st_reg <= cycle_strobe;
      rf_reg <= rf_go | (rf_reg & cycle_strobe);
    end
  end
  property p_low; $rose(cycle_strobe) |-> lo_reg >= 16'd33; endproperty
  property p_wr; $fell(cycle_strobe) && wr_reg && !rsp_valid
    |-> hi_reg >= 16'd58 && hi_reg <= 16'd1000; endproperty
  property p_rmw; $fell(cycle_strobe) && wr_reg && rsp_valid
    |-> hi_reg >= 16'd88 && hi_reg <= 16'd1000; endproperty
  property p_rsp; rsp_valid |-> $fell(cycle_strobe); endproperty
  property p_row; rf_go |-> word_address_lines[5:0] == row_reg; endproperty
  property p_rfrd; rf_reg && cycle_strobe |-> read_write_n; endproperty
  property p_gap; gap_reg <= GAP; endproperty
  property p_sel; !read_write_n |-> !select_n; endproperty
  property p_take; req_valid && req_ready |=> cycle_strobe && !select_n; endproperty
  property p_addr; cycle_strobe && $past(cycle_strobe) |-> $stable(word_address_lines);
  endproperty
  a_low: assert property (p_low) else $error("strobe low too short");
  a_wr: assert property (p_wr) else $error("write strobe width");
  a_rmw: assert property (p_rmw) else $error("rmw strobe width");
  a_rsp: assert property (p_rsp) else $error("answer off strobe fall");
  a_row: assert property (p_row) else $error("refresh row order");
  a_rfrd: assert property (p_rfrd) else $error("refresh not a read");
  a_gap: assert property (p_gap) else $error("refresh too late");
  a_sel: assert property (p_sel) else $error("write while deselected");
  a_take: assert property (p_take) else $error("cycle not started");
  a_addr: assert property (p_addr) else $error("address moved");
  c_wr: cover property ($fell(cycle_strobe) && wr_reg && !rsp_valid);
  c_rmw: cover property ($fell(cycle_strobe) && wr_reg && rsp_valid);
  c_ref: cover property (rf_go);
endmodule
bind dkc_controller dkc_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .word_address_lines(word_address_lines), .cycle_strobe(cycle_strobe),
  .select_n(select_n), .read_write_n(read_write_n));

// file: test/dkc_mem_model.sv
// behavioural 4k x 1 dynamic memory
`timescale 1ns/1ps
module dkc_mem_model (
  // timing and pace
  input wire        sys_clk,
  input wire        slow,
  // memory pins
  input wire [11:0] word_address_lines,
  input wire        cycle_strobe,
  input wire        select_n,
  input wire        read_write_n,
  input wire        mem_din,
  output reg        mem_dout
);
  reg       cells [0:4095]; // storage bits
  reg [7:0] hi_cnt = 8'h0;  // cycles since strobe rose
  reg       junk = 1'b0;    // noise while output floats
  // count strobe time and store writes
  always @(posedge sys_clk) begin
    junk <= ~junk;
    hi_cnt <= cycle_strobe ? hi_cnt + 8'h1 : 8'h0;
    if (cycle_strobe && !select_n && !read_write_n)
      cells[word_address_lines] <= mem_din;
  end
  // drive only when selected and strobed, valid after access delay
  always @* begin
    if (!cycle_strobe || select_n)
      mem_dout = junk;
    else if (hi_cnt >= (slow ? 8'h2d : 8'h08))
      mem_dout = cells[word_address_lines];
    else
      mem_dout = ~junk;
  end
endmodule

// file: test/dkc_controller_tb_top.sv
// self-checking bench for the memory controller
`timescale 1ns/1ps
module dkc_controller_tb_top;
  reg         sys_clk, rst_n, req_valid, req_wdata, req_invert, slow;
  reg  [1:0]  req_op;
  reg  [11:0] req_addr;
  wire        req_ready, rsp_valid, rsp_rdata, cycle_strobe, select_n;
  wire        read_write_n, mem_din, mem_dout;
  wire [11:0] word_address_lines;
  reg  [16:0] rows [0:12]; // op, address, write bit, invert, expected
  integer     error_cnt, checks_done, cyc, i, w, rises, r0;
  reg         st_d;        // last strobe level
  dkc_controller dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_invert(req_invert), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address_lines(word_address_lines), .cycle_strobe(cycle_strobe),
    .select_n(select_n), .read_write_n(read_write_n), .mem_din(mem_din), .mem_dout(mem_dout));
  dkc_mem_model u_mem (.sys_clk(sys_clk), .slow(slow), .mem_din(mem_din),
    .word_address_lines(word_address_lines), .cycle_strobe(cycle_strobe),
    .select_n(select_n), .read_write_n(read_write_n), .mem_dout(mem_dout));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // count cycles and strobe starts, cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    st_d <= cycle_strobe;
    if (cycle_strobe && !st_d)
      rises <= rises + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // hold a request until taken; ready is looked at settled, on the falling edge
  task do_req(input [1:0] op, input [11:0] a, input wd, input inv);
    @(posedge sys_clk);
    {req_valid, req_op, req_addr, req_wdata, req_invert} <= {1'b1, op, a, wd, inv};
    w = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && w < 400) begin
      @(negedge sys_clk);
      w = w + 1;
    end
    if (w >= 400)
      error_cnt = error_cnt + 1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  // wait for the answer pulse and compare the bit
  task wait_rsp(input e);
    w = 0;
    while (rsp_valid !== 1'b1 && w < 400) begin
      @(negedge sys_clk);
      w = w + 1;
    end
    check(12'({rsp_valid, rsp_rdata}), 12'({1'b1, e}));
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------
  // main sequence
  // ------------
  initial begin
    {rst_n, req_valid, req_op, req_addr, req_wdata, req_invert, slow, st_d} = 20'h0;
    {error_cnt, checks_done, cyc, rises} = 128'h0;
    rows[0] = {2'h1, 12'habc, 3'h4};
    rows[1] = {2'h1, 12'h543, 3'h0};
    rows[2] = {2'h1, 12'h000, 3'h4};
    rows[3] = {2'h1, 12'hfff, 3'h0};
    rows[4] = {2'h0, 12'habc, 3'h1};
    rows[5] = {2'h0, 12'h543, 3'h0};
    rows[6] = {2'h2, 12'habc, 3'h3};
    rows[7] = {2'h0, 12'habc, 3'h0};
    rows[8] = {2'h2, 12'h543, 3'h0};
    rows[9] = {2'h3, 12'h000, 3'h1};
    rows[10] = {2'h0, 12'hfff, 3'h0};
    rows[11] = {2'h2, 12'hfff, 3'h2};
    rows[12] = {2'h0, 12'hfff, 3'h1};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 13; i = i + 1) begin
      slow <= i[0];
      do_req(rows[i][16:15], rows[i][14:3], rows[i][2], rows[i][1]);
      if (rows[i][16:15] != 2'h1)
        wait_rsp(rows[i][0]);
    end
    $display("table test done");
    r0 = rises;
    repeat (16000) @(posedge sys_clk);
    check(12'(rises - r0 >= 2), 12'h1);
    do_req(2'h0, 12'h000, 1'b0, 1'b0);
    wait_rsp(1'b1);
    $display("refresh test done");
    do_req(2'h0, 12'habc, 1'b0, 1'b0);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    check(12'({cycle_strobe, select_n, read_write_n, rsp_valid}), 12'h6);
    check(word_address_lines, 12'h0);
    rst_n <= 1'b1;
    do_req(2'h2, 12'h543, 1'b0, 1'b1);
    check(12'(w >= 31), 12'h1);
    wait_rsp(1'b0);
    do_req(2'h0, 12'h543, 1'b0, 1'b0);
    wait_rsp(1'b1);
    $display("reset test done");
    give_verdict;
  end
endmodule
